/* logic/lcu_map.svh */
`ifndef LCU_MAP_SVH
`define LCU_MAP_SVH

// Break field: base length and selector field inside aux_serial_control_reg
`define LCU_BRK_BASE   6'h0d
`define LCU_BRK_MSB    4
`define LCU_BRK_LSB    2
// Shortest low period accepted as a received break, in bit times
`define LCU_BRK_VALID  5'h0b
`define LCU_BRK_SAT    5'h1f
// Input routing bits of input_route_reg
`define LCU_ROUTE_EXT  0
`define LCU_ROUTE_CAP  1
// Extra operating clocks between stop and next start in back-to-back mode
`define LCU_GAP_CYC    6'h02
// Reset values
`define LCU_SHIFT_RST  8'hff
`define LCU_BUF_RST    8'hff
`define LCU_LINE_IDLE  1'b1
// Character lengths
`define LCU_BITS7      4'h7
`define LCU_BITS8      4'h8
`define LCU_LAST7      4'h6
`define LCU_LAST8      4'h7
// Clock source selector: sources fx/2^0 .. fx/2^11
`define LCU_SRC_LAST   4'hb

`endif

/* logic/lcu_pkg.sv */
package lcu_pkg;

   typedef struct packed {
      logic       unit_power_on;
      logic       tx_enable_bit;
      logic       rx_enable_bit;
      logic       char7;
      logic       msb_first;
      logic       tx_invert;
      logic       parity_en;
      logic       parity_odd;
      logic [3:0] clk_sel;
      logic [7:0] baud_divider_ctrl;
      logic [7:0] aux_serial_control_reg;
      logic [1:0] input_route_reg;
   } lcu_cfg_t;

   typedef struct packed {
      logic overrun_flag;
      logic parity_err_flag;
      logic framing_err_flag;
      logic rx_full;
      logic break_rx_mode;
   } lcu_rx_stat_t;

   typedef enum logic [2:0] {
      TX_IDLE, TX_START, TX_DATA, TX_PAR, TX_STOP, TX_GAP, TX_BRK
   } lcu_tx_st_t;

   typedef enum logic [2:0] {
      RX_IDLE, RX_START, RX_DATA, RX_PAR, RX_STOP, RX_BRK
   } lcu_rx_st_t;

   typedef struct packed {
      logic [10:0] cnt;
      logic        tick;
   } lcu_pre_st_t;

   typedef struct packed {
      logic [7:0] cnt;
      logic       tick;
   } lcu_baud_st_t;

   typedef struct packed {
      logic         sync_a;
      logic         sync_b;
      logic         rx_prev;
      lcu_rx_st_t   rx_st;
      logic         rx_half;
      logic [3:0]   rx_bit;
      logic [7:0]   rx_shift;
      logic         rx_par;
      logic [4:0]   brk_cnt;
      logic [7:0]   rx_buf;
      lcu_rx_stat_t stat;
      logic         rx_done;
      logic         rx_err;
      logic         brk_done;
      lcu_tx_st_t   tx_st;
      logic         tx_half;
      logic [3:0]   tx_bit;
      logic [5:0]   tx_cnt;
      logic [7:0]   tx_sh;
      logic [7:0]   tx_buf;
      logic         tx_pend;
      logic         tx_par;
      logic         tx_line;
      logic         tx_done;
      logic         tx_busy;
      logic         out;
      logic         ext_irq;
      logic         cap_in;
   } lcu_state_t;

endpackage : lcu_pkg

/* logic/lcu_prescale.sv */
`timescale 1ns/10ps
`default_nettype none
`include "lcu_map.svh"

module lcu_prescale (
   // Clock and reset
   input  wire logic       clock,
   input  wire logic       rst_n,
   // Source select and tick
   input  wire logic [3:0] sel,
   output logic            base_tick
);

   lcu_pkg::lcu_pre_st_t q;
   lcu_pkg::lcu_pre_st_t d;

   // One of twelve operating clocks, as an enable every 2^sel cycles
   always_comb begin
      logic [3:0]  s;
      logic [10:0] mask;
      s    = (sel > `LCU_SRC_LAST) ? `LCU_SRC_LAST : sel;
      mask = 11'((12'h001 << s) - 12'h001);
      d      = q;
      d.cnt  = q.cnt + 11'h001;
      d.tick = ((q.cnt & mask) == mask);
   end

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         q <= '0;
      end else begin
         q <= d;
      end
   end

   assign base_tick = q.tick;

endmodule : lcu_prescale

`default_nettype wire

/* logic/lcu_baud.sv */
`timescale 1ns/10ps
`default_nettype none

module lcu_baud (
   // Clock and reset
   input  wire logic       clock,
   input  wire logic       rst_n,
   // Control
   input  wire logic       base_tick,
   input  wire logic       run,
   input  wire logic [7:0] div,
   // Half-bit tick
   output logic            tick
);

   lcu_pkg::lcu_baud_st_t q;
   lcu_pkg::lcu_baud_st_t d;

   // 8-bit divider; a value of zero divides by 256
   always_comb begin
      d      = q;
      d.tick = 1'b0;
      if (!run) begin
         d.cnt = '0;
      end else if (base_tick) begin
         if (q.cnt == 8'(div - 8'h01)) begin
            d.cnt  = '0;
            d.tick = 1'b1;
         end else begin
            d.cnt = q.cnt + 8'h01;
         end
      end
   end

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         q <= '0;
      end else begin
         q <= d;
      end
   end

   assign tick = q.tick;

endmodule : lcu_baud

`default_nettype wire

/* logic/lcu_lin_serial_unit.sv */
`timescale 1ns/10ps
`default_nettype none
`include "lcu_map.svh"

module lcu_lin_serial_unit (
   // Clock and reset
   input  wire logic                  clock,
   input  wire logic                  rst_n,
   // Configuration
   input  wire lcu_pkg::lcu_cfg_t     cfg,
   // Transmit requests
   input  wire logic                  tx_write,
   input  wire logic [7:0]            tx_data,
   input  wire logic                  tx_break_start,
   // Receive control
   input  wire logic                  rx_read,
   input  wire logic                  err_clear,
   input  wire logic                  break_rx_arm,
   // Serial pins
   input  wire logic                  serial_in_pin,
   output logic                       serial_out_pin,
   // Transmit status
   output logic                       tx_done_irq,
   output logic                       tx_busy,
   output logic                       tx_buf_full,
   // Receive status
   output logic [7:0]                 rx_holding_buffer,
   output lcu_pkg::lcu_rx_stat_t      rx_status,
   output logic                       rx_done_irq,
   output logic                       rx_err_irq,
   output logic                       break_rx_irq,
   // Routed receive input
   output logic                       ext_irq_input,
   output logic                       capture_timer_input
);

   lcu_pkg::lcu_state_t q;
   lcu_pkg::lcu_state_t d;

   logic unit_rst_n;
   logic base_tick;
   logic tx_tick;
   logic rx_tick;
   logic tx_run;
   logic rx_run;

   // Power bit low holds the whole unit in asynchronous reset
   assign unit_rst_n = rst_n & cfg.unit_power_on;

   // Dividers start from the next state so the first bit is not a clock too long
   assign tx_run = (d.tx_st != lcu_pkg::TX_IDLE) && (d.tx_st != lcu_pkg::TX_GAP);
   assign rx_run = (d.rx_st != lcu_pkg::RX_IDLE);

   lcu_prescale u_pre (
      .clock     (clock),
      .rst_n     (unit_rst_n),
      .sel       (cfg.clk_sel),
      .base_tick (base_tick)
   );

   // Separate dividers keep the two directions independent
   lcu_baud u_tx_baud (
      .clock     (clock),
      .rst_n     (unit_rst_n),
      .base_tick (base_tick),
      .run       (tx_run),
      .div       (cfg.baud_divider_ctrl),
      .tick      (tx_tick)
   );

   lcu_baud u_rx_baud (
      .clock     (clock),
      .rst_n     (unit_rst_n),
      .base_tick (base_tick),
      .run       (rx_run),
      .div       (cfg.baud_divider_ctrl),
      .tick      (rx_tick)
   );

   always_comb begin
      logic       rx_ctr;
      logic       tx_end;
      logic       go;
      logic       bitv;
      logic       fe;
      logic       pe;
      logic       ov;
      logic [3:0] rx_last;
      logic [3:0] tx_bits;
      logic [2:0] brk_sel;
      rx_ctr  = rx_tick & q.rx_half;
      tx_end  = tx_tick & q.tx_half;
      go      = 1'b0;
      fe      = 1'b0;
      pe      = 1'b0;
      ov      = 1'b0;
      rx_last = cfg.char7 ? `LCU_LAST7 : `LCU_LAST8;
      tx_bits = cfg.char7 ? `LCU_BITS7 : `LCU_BITS8;
      brk_sel = cfg.aux_serial_control_reg[`LCU_BRK_MSB:`LCU_BRK_LSB];
      bitv    = cfg.msb_first ? q.tx_sh[3'h7 - q.tx_bit[2:0]]
                              : q.tx_sh[q.tx_bit[2:0]];

      d          = q;
      d.rx_done  = 1'b0;
      d.rx_err   = 1'b0;
      d.brk_done = 1'b0;
      d.tx_done  = 1'b0;
      d.sync_a   = serial_in_pin;
      d.sync_b   = q.sync_a;
      d.rx_prev  = q.sync_b;

      // Receive path
      if (rx_read) begin
         d.stat.rx_full = 1'b0;
      end
      if (err_clear) begin
         d.stat.overrun_flag     = 1'b0;
         d.stat.parity_err_flag  = 1'b0;
         d.stat.framing_err_flag = 1'b0;
      end
      if (rx_tick) begin
         d.rx_half = !q.rx_half;
      end
      if (!cfg.rx_enable_bit) begin
         d.rx_st   = lcu_pkg::RX_IDLE;
         d.rx_half = 1'b0;
      end else begin
         case (q.rx_st)
            lcu_pkg::RX_IDLE: begin
               d.rx_half = 1'b0;
               if (q.rx_prev && !q.sync_b) begin
                  d.rx_st = lcu_pkg::RX_START;
               end
            end
            lcu_pkg::RX_START: begin
               if (rx_tick) begin
                  d.rx_half = 1'b0;
                  d.rx_bit  = '0;
                  d.rx_par  = 1'b0;
                  d.brk_cnt = 5'h01;
                  if (q.sync_b) begin
                     d.rx_st = lcu_pkg::RX_IDLE;
                  end else if (q.stat.break_rx_mode) begin
                     d.rx_st    = lcu_pkg::RX_BRK;
                     d.rx_shift = `LCU_SHIFT_RST;
                  end else begin
                     d.rx_st    = lcu_pkg::RX_DATA;
                     d.rx_shift = `LCU_SHIFT_RST;
                  end
               end
            end
            lcu_pkg::RX_DATA: begin
               if (rx_ctr) begin
                  d.rx_shift = cfg.msb_first ? {q.rx_shift[6:0], q.sync_b}
                                             : {q.sync_b, q.rx_shift[7:1]};
                  d.rx_par   = q.rx_par ^ q.sync_b;
                  d.rx_bit   = q.rx_bit + 4'h1;
                  if (q.rx_bit == rx_last) begin
                     d.rx_st = cfg.parity_en ? lcu_pkg::RX_PAR : lcu_pkg::RX_STOP;
                  end
               end
            end
            lcu_pkg::RX_PAR: begin
               if (rx_ctr) begin
                  d.rx_par = q.rx_par ^ q.sync_b;
                  d.rx_st  = lcu_pkg::RX_STOP;
               end
            end
            lcu_pkg::RX_STOP: begin
               if (rx_ctr) begin
                  d.rx_st   = lcu_pkg::RX_IDLE;
                  d.rx_done = 1'b1;
                  fe = !q.sync_b;
                  pe = cfg.parity_en & (q.rx_par != cfg.parity_odd);
                  ov = q.stat.rx_full;
                  if (!ov) begin
                     d.stat.rx_full = 1'b1;
                     if (!cfg.char7) begin
                        d.rx_buf = q.rx_shift;
                     end else if (cfg.msb_first) begin
                        d.rx_buf = {q.rx_shift[6:0], 1'b0};
                     end else begin
                        d.rx_buf = {1'b0, q.rx_shift[7:1]};
                     end
                  end
                  d.rx_err = fe | pe | ov;
               end
            end
            lcu_pkg::RX_BRK: begin
               // Only counts low bit times; errors and buffer are untouched
               if (rx_ctr) begin
                  if (!q.sync_b) begin
                     if (q.brk_cnt != `LCU_BRK_SAT) begin
                        d.brk_cnt = q.brk_cnt + 5'h01;
                     end
                  end else begin
                     d.rx_st = lcu_pkg::RX_IDLE;
                     if (q.brk_cnt >= `LCU_BRK_VALID) begin
                        d.brk_done           = 1'b1;
                        d.stat.break_rx_mode = 1'b0;
                     end
                  end
               end
            end
            default: begin
               d.rx_st = lcu_pkg::RX_IDLE;
            end
         endcase
      end
      // A new error outranks a clear in the same cycle
      d.stat.overrun_flag     = d.stat.overrun_flag | ov;
      d.stat.parity_err_flag  = d.stat.parity_err_flag | pe;
      d.stat.framing_err_flag = d.stat.framing_err_flag | fe;
      if (break_rx_arm) begin
         d.stat.break_rx_mode = 1'b1;
      end

      // Transmit path
      if (tx_tick) begin
         d.tx_half = !q.tx_half;
      end
      case (q.tx_st)
         lcu_pkg::TX_IDLE: begin
            d.tx_half = 1'b0;
            if (q.tx_pend) begin
               go = 1'b1;
            end else if (tx_break_start) begin
               d.tx_st   = lcu_pkg::TX_BRK;
               d.tx_line = 1'b0;
               d.tx_cnt  = `LCU_BRK_BASE + {3'h0, brk_sel};
            end
         end
         lcu_pkg::TX_START: begin
            if (tx_end) begin
               d.tx_st   = lcu_pkg::TX_DATA;
               d.tx_line = bitv;
               d.tx_par  = bitv;
               d.tx_bit  = 4'h1;
            end
         end
         lcu_pkg::TX_DATA: begin
            if (tx_end) begin
               if (q.tx_bit == tx_bits) begin
                  d.tx_st   = cfg.parity_en ? lcu_pkg::TX_PAR : lcu_pkg::TX_STOP;
                  d.tx_line = cfg.parity_en ? (q.tx_par ^ cfg.parity_odd) : `LCU_LINE_IDLE;
               end else begin
                  d.tx_line = bitv;
                  d.tx_par  = q.tx_par ^ bitv;
                  d.tx_bit  = q.tx_bit + 4'h1;
               end
            end
         end
         lcu_pkg::TX_PAR: begin
            if (tx_end) begin
               d.tx_st   = lcu_pkg::TX_STOP;
               d.tx_line = `LCU_LINE_IDLE;
            end
         end
         lcu_pkg::TX_STOP: begin
            if (tx_end) begin
               d.tx_done = 1'b1;
               if (q.tx_pend) begin
                  d.tx_st  = lcu_pkg::TX_GAP;
                  d.tx_cnt = `LCU_GAP_CYC;
               end else begin
                  d.tx_st = lcu_pkg::TX_IDLE;
               end
            end
         end
         lcu_pkg::TX_GAP: begin
            if (base_tick) begin
               d.tx_cnt = q.tx_cnt - 6'h01;
               go       = (q.tx_cnt == 6'h01);
            end
         end
         lcu_pkg::TX_BRK: begin
            if (tx_end) begin
               d.tx_cnt = q.tx_cnt - 6'h01;
               if (q.tx_cnt == 6'h01) begin
                  d.tx_st   = lcu_pkg::TX_IDLE;
                  d.tx_line = `LCU_LINE_IDLE;
                  d.tx_done = 1'b1;
               end
            end
         end
         default: begin
            d.tx_st = lcu_pkg::TX_IDLE;
         end
      endcase
      if (go) begin
         d.tx_st   = lcu_pkg::TX_START;
         d.tx_line = 1'b0;
         d.tx_sh   = q.tx_buf;
         d.tx_bit  = '0;
         d.tx_pend = 1'b0;
         d.tx_half = 1'b0;
      end
      if (tx_write) begin
         d.tx_buf  = tx_data;
         d.tx_pend = 1'b1;
      end
      if (!cfg.tx_enable_bit) begin
         d.tx_st   = lcu_pkg::TX_IDLE;
         d.tx_line = `LCU_LINE_IDLE;
         d.tx_pend = 1'b0;
         d.tx_half = 1'b0;
         d.tx_done = 1'b0;
      end
      d.tx_busy = (d.tx_st != lcu_pkg::TX_IDLE);
      d.out     = d.tx_line ^ cfg.tx_invert;

      // Internal routing of the synchronised receive line
      d.ext_irq = cfg.input_route_reg[`LCU_ROUTE_EXT] ? q.sync_b : `LCU_LINE_IDLE;
      d.cap_in  = cfg.input_route_reg[`LCU_ROUTE_CAP] ? q.sync_b : `LCU_LINE_IDLE;
   end

   // State only moves on clock edges or the asynchronous reset, so a stopped clock freezes it
   always_ff @(posedge clock or negedge unit_rst_n) begin
      if (!unit_rst_n) begin
         q          <= '0;
         q.sync_a   <= `LCU_LINE_IDLE;
         q.sync_b   <= `LCU_LINE_IDLE;
         q.rx_prev  <= `LCU_LINE_IDLE;
         q.rx_shift <= `LCU_SHIFT_RST;
         q.rx_buf   <= `LCU_BUF_RST;
         q.tx_buf   <= `LCU_BUF_RST;
         q.tx_line  <= `LCU_LINE_IDLE;
         q.out      <= `LCU_LINE_IDLE;
         q.ext_irq  <= `LCU_LINE_IDLE;
         q.cap_in   <= `LCU_LINE_IDLE;
      end else begin
         q <= d;
      end
   end

   assign serial_out_pin      = q.out;
   assign tx_done_irq         = q.tx_done;
   assign tx_busy             = q.tx_busy;
   assign tx_buf_full         = q.tx_pend;
   assign rx_holding_buffer   = q.rx_buf;
   assign rx_status           = q.stat;
   assign rx_done_irq         = q.rx_done;
   assign rx_err_irq          = q.rx_err;
   assign break_rx_irq        = q.brk_done;
   assign ext_irq_input       = q.ext_irq;
   assign capture_timer_input = q.cap_in;

endmodule : lcu_lin_serial_unit

`default_nettype wire

/* bench/lcu_lin_serial_unit_asserts.sv */
`timescale 1ns/10ps
`default_nettype none
module lcu_chk (
   // Clock and reset
   input wire logic                  clock,
   input wire logic                  rst_n,
   // Inputs watched
   input wire lcu_pkg::lcu_cfg_t     cfg,
   input wire logic                  tx_write,
   // Outputs watched
   input wire logic                  serial_out_pin,
   input wire logic                  tx_done_irq,
   input wire logic                  tx_busy,
   input wire logic                  tx_buf_full,
   input wire logic [7:0]            rx_holding_buffer,
   input wire lcu_pkg::lcu_rx_stat_t rx_status,
   input wire logic                  rx_done_irq,
   input wire logic                  rx_err_irq,
   input wire logic                  break_rx_irq,
   input wire logic                  ext_irq_input
);
   default clocking @(posedge clock); endclocking
   default disable iff (!rst_n);

   a_power_off_idle: assert property (
      !cfg.unit_power_on |-> serial_out_pin && !tx_busy && ext_irq_input)
      else $error("outputs not idle while powered off");
   a_tx_disable_idle: assert property (
      !cfg.tx_enable_bit |=> !tx_busy && !tx_buf_full)
      else $error("transmitter not idled by disable");
   a_idle_line_pol: assert property (
      cfg.unit_power_on && !tx_busy && !$past(tx_busy) && $stable(cfg)
      |-> serial_out_pin == !cfg.tx_invert)
      else $error("idle line level wrong");
   a_start_follows: assert property (
      tx_write && cfg.tx_enable_bit && cfg.unit_power_on && !tx_busy && !tx_buf_full
      |-> ##2 serial_out_pin == cfg.tx_invert)
      else $error("start bit missing after write");
   a_done_one_cycle: assert property (tx_done_irq |=> !tx_done_irq)
      else $error("transmit done longer than one cycle");
   a_done_ends_busy: assert property (
      $fell(tx_busy) && cfg.unit_power_on && cfg.tx_enable_bit && $past(cfg.tx_enable_bit)
      |-> tx_done_irq)
      else $error("transmitter went idle without done");
   a_brk_quiet: assert property (
      break_rx_irq |-> !rx_done_irq && !rx_err_irq && $stable(rx_holding_buffer))
      else $error("break reception touched data path");
   a_brk_from_mode: assert property (break_rx_irq |-> $past(rx_status.break_rx_mode))
      else $error("break interrupt outside break mode");
   a_brk_mode_exit: assert property (
      break_rx_irq |-> ##[0:1] !rx_status.break_rx_mode)
      else $error("break mode kept after valid break");
   a_route_idle_high: assert property (
      !cfg.input_route_reg[0] && !$past(cfg.input_route_reg[0]) |-> ext_irq_input)
      else $error("unrouted interrupt input not high");

   c_tx_done: cover property (tx_done_irq);
   c_brk_rx: cover property (break_rx_irq);
   c_rx_good: cover property (rx_done_irq && !rx_err_irq);
endmodule : lcu_chk

bind lcu_lin_serial_unit lcu_chk u_chk (
   .clock, .rst_n, .cfg, .tx_write, .serial_out_pin, .tx_done_irq, .tx_busy,
   .tx_buf_full, .rx_holding_buffer, .rx_status, .rx_done_irq, .rx_err_irq,
   .break_rx_irq, .ext_irq_input
);
`default_nettype wire

/* bench/lcu_lin_node.sv */
`timescale 1ns/10ps
`default_nettype none
module lcu_lin_node #(
   parameter int BIT = 16
) (
   // Clock
   input  wire logic clock,
   // Bus wires
   input  wire logic tx_line,
   output var logic  bus_line
);
   initial bus_line = 1'h1;

   // Dominant low for n bit times, then released to the pulled-up level
   task automatic drive_low(input int n);
      bus_line = 1'h0;
      repeat (n * BIT) @(negedge clock);
      bus_line = 1'h1;
   endtask : drive_low

   task automatic send(input logic [7:0] d, input int n, input logic msb);
      drive_low(1);
      for (int i = 0; i < n; i++) begin
         bus_line = msb ? d[7 - i] : d[i];
         repeat (BIT) @(negedge clock);
      end
      bus_line = 1'h1;
      repeat (BIT) @(negedge clock);
   endtask : send

   // Mid-bit sampling of one frame; ok low on timeout or bad stop
   task automatic catch(input int n, input logic inv, input logic msb,
                        output logic [7:0] d, output logic ok);
      int t;
      d = 8'h00;
      t = 0;
      while (tx_line !== inv && t < 400) begin
         @(negedge clock);
         t++;
      end
      repeat (BIT / 2) @(negedge clock);
      for (int i = 0; i < n; i++) begin
         repeat (BIT) @(negedge clock);
         if (msb) d[7 - i] = tx_line ^ inv;
         else d[i] = tx_line ^ inv;
      end
      repeat (BIT) @(negedge clock);
      ok = (t < 400) && (tx_line === !inv);
   endtask : catch
endmodule : lcu_lin_node
`default_nettype wire

/* bench/lcu_lin_serial_unit_tb.sv */
`timescale 1ns/10ps
`default_nettype none
module lcu_lin_serial_unit_tb;
   // Bit time in clocks: clk_sel 0, divider 8, two halves
   localparam int BIT = 16;
   logic                  clock, rst_n, tx_write, tx_break_start, rx_read;
   logic                  err_clear, break_rx_arm, serial_in_pin, serial_out_pin;
   logic                  tx_done_irq, tx_busy, tx_buf_full, rx_done_irq;
   logic                  rx_err_irq, break_rx_irq, ext_irq_input, capture_timer_input;
   logic [7:0]            tx_data, rx_holding_buffer;
   lcu_pkg::lcu_cfg_t     cfg;
   lcu_pkg::lcu_rx_stat_t rx_status;
   int                    err_count, compares, cyc, fall_a, fall_b, rise_t, n_done, n_brk;
   logic                  out_q = 1'h1;

   lcu_lin_serial_unit dut (
      .clock, .rst_n, .cfg, .tx_write, .tx_data, .tx_break_start, .rx_read, .err_clear,
      .break_rx_arm, .serial_in_pin, .serial_out_pin, .tx_done_irq, .tx_busy,
      .tx_buf_full, .rx_holding_buffer, .rx_status, .rx_done_irq, .rx_err_irq,
      .break_rx_irq, .ext_irq_input, .capture_timer_input
   );
   lcu_lin_node #(.BIT(BIT)) node (.clock, .tx_line(serial_out_pin), .bus_line(serial_in_pin));

   initial begin
      clock = 1'h0;
      forever #20 clock = ~clock;
   end

   // Edge times of the line and interrupt counts
   always @(posedge clock) begin
      cyc++;
      if (out_q && !serial_out_pin) begin
         fall_a = fall_b;
         fall_b = cyc;
      end
      if (!out_q && serial_out_pin) rise_t = cyc;
      out_q = serial_out_pin;
      if (tx_done_irq === 1'h1) n_done++;
      if (break_rx_irq === 1'h1) n_brk++;
   end

   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      compares++;
      if (seen !== exp) begin
         err_count++;
         $display("mismatch at %0t: got %h want %h", $time, seen, exp);
      end
   endtask : check

   task automatic final_report;
      if (err_count == 0 && compares > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask : final_report

   function automatic logic [7:0] fmt(input logic [7:0] d, input logic c7, input logic msb);
      if (!c7) return d;
      return msb ? {d[7:1], 1'h0} : {1'h0, d[6:0]};
   endfunction : fmt

   task automatic mode(input logic c7, input logic msb, input logic inv);
      cfg.char7 = c7;
      cfg.msb_first = msb;
      cfg.tx_invert = inv;
      repeat (2) @(negedge clock);
   endtask : mode

   task automatic send_tx(input logic [7:0] d);
      tx_data = d;
      tx_write = 1'h1;
      @(negedge clock);
      tx_write = 1'h0;
   endtask : send_tx

   task automatic tx_case(input logic [7:0] d, input logic c7, input logic msb, input logic inv);
      logic [7:0] got;
      logic       ok;
      int         n0;
      mode(c7, msb, inv);
      n0 = n_done;
      send_tx(d);
      node.catch(c7 ? 7 : 8, inv, msb, got, ok);
      check(16'(ok), 16'h0001);
      if (ok !== 1'h1) final_report;
      check(16'(got), 16'(fmt(d, c7, msb)));
      repeat (BIT) @(negedge clock);
      check(16'(n_done - n0), 16'h0001);
   endtask : tx_case

   task automatic rx_case(input logic [7:0] d, input logic c7, input logic msb);
      mode(c7, msb, 1'h0);
      node.send(d, c7 ? 7 : 8, msb);
      check(16'(rx_holding_buffer), 16'(fmt(d, c7, msb)));
      check(16'(rx_status[4:2]), 16'h0000);
      rx_read = 1'h1;
      @(negedge clock);
      rx_read = 1'h0;
   endtask : rx_case

   task automatic brk_tx(input int sel);
      int n0;
      n0 = n_done;
      cfg.aux_serial_control_reg = {3'h0, 3'(sel), 2'h0};
      @(negedge clock);
      tx_break_start = 1'h1;
      @(negedge clock);
      tx_break_start = 1'h0;
      repeat ((14 + sel) * BIT) @(negedge clock);
      check(16'(rise_t - fall_b), 16'((13 + sel) * BIT));
      check(16'(n_done - n0), 16'h0001);
   endtask : brk_tx

   task automatic brk_rx(input int n, input logic good);
      int         n0;
      logic [7:0] b0;
      n0 = n_brk;
      b0 = rx_holding_buffer;
      break_rx_arm = 1'h1;
      @(negedge clock);
      break_rx_arm = 1'h0;
      node.drive_low(n);
      repeat (2 * BIT) @(negedge clock);
      check(16'(n_brk - n0), 16'(good));
      check(16'(rx_status.break_rx_mode), 16'(!good));
      check(16'({rx_holding_buffer, 5'(rx_status[4:2])}), 16'({b0, 5'h00}));
   endtask : brk_rx

   initial begin
      cfg = '0;
      cfg.unit_power_on = 1'h1;
      cfg.tx_enable_bit = 1'h1;
      cfg.rx_enable_bit = 1'h1;
      cfg.baud_divider_ctrl = 8'h08;
      {tx_write, tx_break_start, rx_read, err_clear, break_rx_arm} = 5'h00;
      tx_data = 8'h00;
      rst_n = 1'h0;
      repeat (5) @(negedge clock);
      rst_n = 1'h1;
      repeat (2) @(negedge clock);
      tx_case(8'h80, 1'h0, 1'h0, 1'h0);
      tx_case(8'ha5, 1'h1, 1'h1, 1'h1);
      tx_case(8'h3c, 1'h1, 1'h0, 1'h0);
      tx_case(8'hc3, 1'h0, 1'h1, 1'h1);
      mode(1'h0, 1'h0, 1'h0);
      send_tx(8'hff);
      repeat (4) @(negedge clock);
      send_tx(8'hff);
      repeat (24 * BIT) @(negedge clock);
      check(16'(fall_b - fall_a), 16'(10 * BIT + 2));
      for (int s = 0; s < 8; s++) brk_tx(s);
      rx_case(8'h96, 1'h0, 1'h1);
      rx_case(8'hb7, 1'h1, 1'h0);
      rx_case(8'hb7, 1'h1, 1'h1);
      brk_rx(10, 1'h0);
      brk_rx(11, 1'h1);
      fork
         tx_case(8'h96, 1'h0, 1'h0, 1'h0);
         rx_case(8'h55, 1'h0, 1'h0);
      join
      cfg.rx_enable_bit = 1'h0;
      @(negedge clock);
      cfg.baud_divider_ctrl = 8'h08;
      cfg.rx_enable_bit = 1'h1;
      rx_case(8'h3a, 1'h0, 1'h0);
      cfg.rx_enable_bit = 1'h0;
      for (int r = 0; r < 4; r++) begin
         cfg.input_route_reg = 2'(r);
         fork
            node.drive_low(1);
            begin
               repeat (8) @(negedge clock);
               check(16'({ext_irq_input, capture_timer_input}), 16'({!r[0], !r[1]}));
            end
         join
      end
      send_tx(8'h00);
      repeat (3 * BIT) @(negedge clock);
      cfg.tx_enable_bit = 1'h0;
      repeat (2) @(negedge clock);
      check(16'({serial_out_pin, tx_busy, tx_buf_full}), 16'h0004);
      cfg.tx_invert = 1'h1;
      cfg.unit_power_on = 1'h0;
      @(negedge clock);
      check(16'({serial_out_pin, rx_holding_buffer}), 16'h01ff);
      final_report;
   end
endmodule : lcu_lin_serial_unit_tb
`default_nettype wire
